/* File: hw/spdcs_top.sv */
// channel status registers and receiver input selection
// How it works
// - the source number sits in bits 3:0 of the third transmit status register, goes out as status bits 19:16, and resets to zero.
// - subframe 1 channel code 01 sends 0001, 10 sends 0010, and 00 or 11 send 0000 on status bits 23:20.
// - subframe 2 uses the same channel mapping from its own field in bits 7:6, reset 00.
// - both subframes carry identical status except the channel number taken from each subframe's own field.
// - the 4-bit sampling frequency code goes out as status bits 27:24 and resets to 0001.
// - the 2-bit clock accuracy code goes out as status bits 29:28 and resets to 11.
// - the original sampling frequency code goes out as status bits 39:36 and resets to 0000.
// - the primary input mode bit, reset 1, selects comparator when 1 and CMOS input when 0.
// - the 2-bit input select, reset 00, picks input 1, 2, 3 or 4 for the receiver.
// - at most one of the four inputs reaches the decoder at any time, and none from the cycle after the receiver is powered down.
// - pin config code 1110 makes a CMOS serial input, 1111 a comparator one; resets are 0010, 0011 and 0100.
// - bit 5 of the second power-down register disables the receiver when 1, its reset value.
// - status goes out one bit per subframe, in a 192-frame block per subframe.
// - with received data as the source the recovered status passes unless overwrite is set.
`include "spdcs_map.svh"

module spdcs_top #(
    parameter int ADDR_W = 7
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    input  wire logic        REG_WR_EN,
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [7:0]  REG_WR_DATA,
    output logic      [7:0]  REG_RD_DATA,
    input  wire logic        PRIMARY_SERIAL_INPUT,
    input  wire logic [2:0]  MULTI_PIN_IN,
    output logic      [2:0]  MULTI_PIN_IS_INPUT,
    output logic      [2:0]  MULTI_PIN_COMPARATOR,
    output logic             PRIMARY_INPUT_COMPARATOR,
    output logic             RECEIVER_POWER_DOWN,
    output logic             RX_DECODER_IN,
    input  wire logic        SUBFRAME_STROBE,
    input  wire logic        SECOND_SUBFRAME,
    input  wire logic [1:0]  TRANSMIT_SOURCE_SELECT,
    input  wire logic        STATUS_OVERWRITE,
    input  wire logic        RECOVERED_STATUS_BIT,
    input  wire logic [15:0] TX_STATUS_LOW,
    output logic             STATUS_BIT_OUT,
    output logic             STATUS_BIT_VALID
);
    if (ADDR_W != 7) begin : g_bad_addr_w
        $error("register address must be 7 bits");
    end

    // a bit of a literal cannot be selected directly, so the reset byte gets a name first
    localparam logic [7:0] PWR_RST = `SPDCS_RST_PWR_DN2;

    logic [7:0] src_chan_reg, src_chan_next;
    logic [7:0] sampling_frequency_code_acc_reg, sampling_frequency_code_acc_next;
    logic [7:0] word_len_reg, word_len_next;
    logic [2:0] mode_sel_reg, mode_sel_next;
    logic [7:0] pin_b_reg,    pin_b_next;
    logic [3:0] pin_c_reg,    pin_c_next;
    logic       pwr_rx_reg,   pwr_rx_next;
    logic [7:0] rd_reg,       rd_next;
    logic       rx_reg,       rx_next;

    logic [3:0]                 pin_cfg [3];
    logic [2:0]                 pin_in_mode;
    spdcs_pkg::spdcs_rx_sel_t   rx_sel;

    function automatic logic is_serial_in(input logic [3:0] code);
        is_serial_in = (code == `SPDCS_PIN_CFG_CMOS) || (code == `SPDCS_PIN_CFG_COMP);
    endfunction

    // ----------------------------------------
    // register writes and read-back
    // ----------------------------------------
    always_comb begin
        src_chan_next = src_chan_reg;
        sampling_frequency_code_acc_next = sampling_frequency_code_acc_reg;
        word_len_next = word_len_reg;
        mode_sel_next = mode_sel_reg;
        pin_b_next    = pin_b_reg;
        pin_c_next    = pin_c_reg;
        pwr_rx_next   = pwr_rx_reg;
        if (REG_WR_EN) begin
            case (REG_ADDR)
                `SPDCS_OFS_SRC_CHAN:  src_chan_next = REG_WR_DATA;
                `SPDCS_OFS_SAMPLING_FREQUENCY_CODE_ACC:  sampling_frequency_code_acc_next = {2'h0, REG_WR_DATA[5:0]};
                `SPDCS_OFS_WORD_LEN:  word_len_next = REG_WR_DATA;
                `SPDCS_OFS_MODE_SEL:  mode_sel_next = REG_WR_DATA[2:0];
                `SPDCS_OFS_PIN_CFG_B: pin_b_next    = REG_WR_DATA;
                `SPDCS_OFS_PIN_CFG_C: pin_c_next    = REG_WR_DATA[3:0];
                `SPDCS_OFS_PWR_DN2:   pwr_rx_next   = REG_WR_DATA[`SPDCS_PWR_RX_BIT];
                default: ;
            endcase
        end
        case (REG_ADDR)
            `SPDCS_OFS_SRC_CHAN:  rd_next = src_chan_reg;
            `SPDCS_OFS_SAMPLING_FREQUENCY_CODE_ACC:  rd_next = sampling_frequency_code_acc_reg;
            `SPDCS_OFS_WORD_LEN:  rd_next = word_len_reg;
            `SPDCS_OFS_MODE_SEL:  rd_next = {5'h00, mode_sel_reg};
            `SPDCS_OFS_PIN_CFG_B: rd_next = pin_b_reg;
            `SPDCS_OFS_PIN_CFG_C: rd_next = {4'h0, pin_c_reg};
            `SPDCS_OFS_PWR_DN2:   rd_next = {2'h0, pwr_rx_reg, 5'h00};
            default:              rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            src_chan_reg <= `SPDCS_RST_SRC_CHAN;
            sampling_frequency_code_acc_reg <= `SPDCS_RST_SAMPLING_FREQUENCY_CODE_ACC;
            word_len_reg <= `SPDCS_RST_WORD_LEN;
            mode_sel_reg <= 3'(`SPDCS_RST_MODE_SEL);
            pin_b_reg    <= `SPDCS_RST_PIN_CFG_B;
            pin_c_reg    <= 4'(`SPDCS_RST_PIN_CFG_C);
            pwr_rx_reg   <= PWR_RST[`SPDCS_PWR_RX_BIT];
            rd_reg       <= 8'h00;
        end else begin
            src_chan_reg <= src_chan_next;
            sampling_frequency_code_acc_reg <= sampling_frequency_code_acc_next;
            word_len_reg <= word_len_next;
            mode_sel_reg <= mode_sel_next;
            pin_b_reg    <= pin_b_next;
            pin_c_reg    <= pin_c_next;
            pwr_rx_reg   <= pwr_rx_next;
            rd_reg       <= rd_next;
        end
    end

    assign REG_RD_DATA = rd_reg;

    // ----------------------------------------
    // receiver input selection
    // ----------------------------------------
    assign pin_cfg[0] = pin_b_reg[3:0];
    assign pin_cfg[1] = pin_b_reg[7:4];
    assign pin_cfg[2] = pin_c_reg;
    assign rx_sel     = spdcs_pkg::spdcs_rx_sel_t'(mode_sel_reg[`SPDCS_MODE_SEL_LSB +: 2]);

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_in_mode[i] = is_serial_in(pin_cfg[i]);
        end
        // an unconfigured pin is held low so a driven output never loops into the decoder
        case (rx_sel)
            spdcs_pkg::SPDCS_SEL_PRIMARY: rx_next = PRIMARY_SERIAL_INPUT;
            spdcs_pkg::SPDCS_SEL_PIN_B:   rx_next = pin_in_mode[0] & MULTI_PIN_IN[0];
            spdcs_pkg::SPDCS_SEL_PIN_C:   rx_next = pin_in_mode[1] & MULTI_PIN_IN[1];
            spdcs_pkg::SPDCS_SEL_PIN_D:   rx_next = pin_in_mode[2] & MULTI_PIN_IN[2];
            default:                      rx_next = 1'b0;
        endcase
        if (pwr_rx_reg) begin
            rx_next = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rx_reg <= 1'b0;
        end else begin
            rx_reg <= rx_next;
        end
    end

    assign RX_DECODER_IN            = rx_reg;
    assign MULTI_PIN_IS_INPUT       = pin_in_mode;
    assign MULTI_PIN_COMPARATOR     = {pin_cfg[2] == `SPDCS_PIN_CFG_COMP, pin_cfg[1] == `SPDCS_PIN_CFG_COMP,
                                       pin_cfg[0] == `SPDCS_PIN_CFG_COMP};
    assign PRIMARY_INPUT_COMPARATOR = mode_sel_reg[`SPDCS_MODE_CIRCUIT_BIT];
    assign RECEIVER_POWER_DOWN      = pwr_rx_reg;

    // ----------------------------------------
    // channel status serialiser
    // ----------------------------------------
    spdcs_cs_if cs_link ();

    assign cs_link.fields = '{low_bits:                TX_STATUS_LOW,
                              source_number:           src_chan_reg[3:0],
                              subframe1_channel_no:    src_chan_reg[5:4],
                              subframe2_channel_no:    src_chan_reg[7:6],
                              sampling_frequency_code: sampling_frequency_code_acc_reg[3:0],
                              clock_accuracy_code:     sampling_frequency_code_acc_reg[5:4],
                              max_length_select:       word_len_reg[0],
                              sent_word_length_code:   word_len_reg[3:1],
                              original_rate_code:      word_len_reg[7:4]};
    assign cs_link.subframe_strobe = SUBFRAME_STROBE;
    assign cs_link.second_subframe = SECOND_SUBFRAME;
    assign cs_link.use_recovered   = (TRANSMIT_SOURCE_SELECT == 2'h0) && !STATUS_OVERWRITE;
    assign cs_link.recovered_bit   = RECOVERED_STATUS_BIT;

    spdcs_cs_gen #(
        .BLOCK_FRAMES (`SPDCS_BLOCK_FRAMES)
    ) u_cs_gen (
        .clk (SYS_CLK),
        .rst (RESET),
        .cs  (cs_link)
    );

    assign STATUS_BIT_OUT   = cs_link.status_bit;
    assign STATUS_BIT_VALID = cs_link.status_valid;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    property p_reset_values;
        $fell(RESET) |-> src_chan_reg == 8'h00 && sampling_frequency_code_acc_reg == 8'h31 && word_len_reg == 8'h0b
                         && mode_sel_reg == 3'h1 && pin_b_reg == 8'h32 && pin_c_reg == 4'h4 && pwr_rx_reg;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset value");

    property p_powered_down_quiet;
        pwr_rx_reg |=> !RX_DECODER_IN;
    endproperty
    a_powered_down_quiet: assert property (p_powered_down_quiet) else $error("decoder fed while off");

    property p_primary_route;
        !pwr_rx_reg && rx_sel == spdcs_pkg::SPDCS_SEL_PRIMARY |=> RX_DECODER_IN == $past(PRIMARY_SERIAL_INPUT);
    endproperty
    a_primary_route: assert property (p_primary_route) else $error("input 1 not routed");

    property p_pin_d_route;
        !pwr_rx_reg && rx_sel == spdcs_pkg::SPDCS_SEL_PIN_D && pin_c_reg == 4'hf
            |=> RX_DECODER_IN == $past(MULTI_PIN_IN[2]);
    endproperty
    a_pin_d_route: assert property (p_pin_d_route) else $error("input 4 not routed");

    property p_unconfigured_blocked;
        rx_sel == spdcs_pkg::SPDCS_SEL_PIN_B && pin_b_reg[3:0] != 4'he && pin_b_reg[3:0] != 4'hf
            |=> !RX_DECODER_IN;
    endproperty
    a_unconfigured_blocked: assert property (p_unconfigured_blocked) else $error("unconfigured pin reached decoder");

    property p_write_source;
        REG_WR_EN && REG_ADDR == `SPDCS_OFS_SRC_CHAN |=> src_chan_reg == $past(REG_WR_DATA);
    endproperty
    a_write_source: assert property (p_write_source) else $error("source register not written");

endmodule // spdcs_top

/* File: hw/spdcs_map.svh */
// offsets, field positions, reset values and counts of the channel status and input select bank
`ifndef SPDCS_MAP_SVH
`define SPDCS_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPDCS_OFS_SRC_CHAN      7'h21
`define SPDCS_OFS_SAMPLING_FREQUENCY_CODE_ACC      7'h22
`define SPDCS_OFS_WORD_LEN      7'h23
`define SPDCS_OFS_MODE_SEL      7'h24
`define SPDCS_OFS_PIN_CFG_B     7'h26
`define SPDCS_OFS_PIN_CFG_C     7'h27
`define SPDCS_OFS_PWR_DN2       7'h33

// ----------------------------------------
// reset values
// ----------------------------------------
`define SPDCS_RST_SRC_CHAN      8'h00
`define SPDCS_RST_SAMPLING_FREQUENCY_CODE_ACC      8'h31
`define SPDCS_RST_WORD_LEN      8'h0b
`define SPDCS_RST_MODE_SEL      8'h01
`define SPDCS_RST_PIN_CFG_B     8'h32
`define SPDCS_RST_PIN_CFG_C     8'h04
`define SPDCS_RST_PWR_DN2       8'h20

// ----------------------------------------
// register field positions
// ----------------------------------------
`define SPDCS_MODE_CIRCUIT_BIT  0
`define SPDCS_MODE_SEL_LSB      1
`define SPDCS_PWR_RX_BIT        5
`define SPDCS_PIN_CFG_CMOS      4'he
`define SPDCS_PIN_CFG_COMP      4'hf

// ----------------------------------------
// channel status bit positions and counts
// ----------------------------------------
`define SPDCS_CS_SRC_LSB        16
`define SPDCS_CS_CHAN_LSB       20
`define SPDCS_CS_SAMPLING_FREQUENCY_CODE_LSB       24
`define SPDCS_CS_ACC_LSB        28
`define SPDCS_CS_MAXLEN_BIT     32
`define SPDCS_CS_WL_LSB         33
`define SPDCS_CS_ORIG_LSB       36
`define SPDCS_CS_USED_BITS      8'h28
`define SPDCS_BLOCK_FRAMES      192

`endif

/* File: hw/spdcs_pkg.sv */
// types shared by the channel status and input select bank
package spdcs_pkg;

    typedef enum logic [1:0] {
        SPDCS_SEL_PRIMARY,
        SPDCS_SEL_PIN_B,
        SPDCS_SEL_PIN_C,
        SPDCS_SEL_PIN_D
    } spdcs_rx_sel_t;

    typedef struct packed {
        logic [15:0] low_bits;
        logic [3:0]  source_number;
        logic [1:0]  subframe1_channel_no;
        logic [1:0]  subframe2_channel_no;
        logic [3:0]  sampling_frequency_code;
        logic [1:0]  clock_accuracy_code;
        logic        max_length_select;
        logic [2:0]  sent_word_length_code;
        logic [3:0]  original_rate_code;
    } spdcs_tx_status_t;

endpackage

/* File: hw/spdcs_cs_if.sv */
// carrier between register bank and channel status serialiser
interface spdcs_cs_if;
    spdcs_pkg::spdcs_tx_status_t fields;
    logic                        subframe_strobe;
    logic                        second_subframe;
    logic                        use_recovered;
    logic                        recovered_bit;
    logic                        status_bit;
    logic                        status_valid;

    modport gen (
        input  fields,
        input  subframe_strobe,
        input  second_subframe,
        input  use_recovered,
        input  recovered_bit,
        output status_bit,
        output status_valid
    );
    modport bank (
        output fields,
        output subframe_strobe,
        output second_subframe,
        output use_recovered,
        output recovered_bit,
        input  status_bit,
        input  status_valid
    );
endinterface

/* File: hw/spdcs_cs_gen.sv */
// channel status serialiser: one bit per subframe over a block of frames
`include "spdcs_map.svh"

module spdcs_cs_gen #(
    parameter int BLOCK_FRAMES = `SPDCS_BLOCK_FRAMES
) (
    input wire logic clk,
    input wire logic rst,
    spdcs_cs_if.gen  cs
);
    if (BLOCK_FRAMES < 40 || BLOCK_FRAMES > 256) begin : g_bad_block
        $error("block length out of range");
    end

    localparam logic [7:0] LAST_FRAME = 8'(BLOCK_FRAMES - 1);

    logic [7:0] frame_reg;
    logic [7:0] frame_next;
    logic       bit_reg;
    logic       bit_next;
    logic       valid_reg;
    logic       valid_next;

    function automatic logic [3:0] chan_code(input logic [1:0] c);
        case (c)
            2'h1:    chan_code = 4'h1;
            2'h2:    chan_code = 4'h2;
            default: chan_code = 4'h0;
        endcase
    endfunction

    function automatic logic cs_bit(input logic [7:0] idx, input logic sub2,
                                    input spdcs_pkg::spdcs_tx_status_t f);
        logic [39:0] v;
        v = '0;
        v[15:0] = f.low_bits;
        v[`SPDCS_CS_SRC_LSB +: 4]  = f.source_number;
        v[`SPDCS_CS_CHAN_LSB +: 4] = chan_code(sub2 ? f.subframe2_channel_no
                                                    : f.subframe1_channel_no);
        v[`SPDCS_CS_SAMPLING_FREQUENCY_CODE_LSB +: 4] = f.sampling_frequency_code;
        v[`SPDCS_CS_ACC_LSB +: 2]  = f.clock_accuracy_code;
        v[`SPDCS_CS_MAXLEN_BIT]    = f.max_length_select;
        v[`SPDCS_CS_WL_LSB +: 3]   = f.sent_word_length_code;
        v[`SPDCS_CS_ORIG_LSB +: 4] = f.original_rate_code;
        // consumer format: only the first 40 bits carry data
        cs_bit = (idx < `SPDCS_CS_USED_BITS) ? v[idx[5:0]] : 1'b0;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        frame_next = frame_reg;
        bit_next   = bit_reg;
        valid_next = cs.subframe_strobe;
        if (cs.subframe_strobe) begin
            bit_next = cs.use_recovered ? cs.recovered_bit
                                        : cs_bit(frame_reg, cs.second_subframe, cs.fields);
            if (cs.second_subframe) begin
                frame_next = (frame_reg == LAST_FRAME) ? 8'h00 : frame_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            frame_reg <= 8'h00;
            bit_reg   <= 1'b0;
            valid_reg <= 1'b0;
        end else begin
            frame_reg <= frame_next;
            bit_reg   <= bit_next;
            valid_reg <= valid_next;
        end
    end

    assign cs.status_bit   = bit_reg;
    assign cs.status_valid = valid_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_last_pair;
        cs.subframe_strobe && cs.second_subframe && frame_reg == LAST_FRAME;
    endsequence

    property p_block_wrap;
        s_last_pair |=> frame_reg == 8'h00;
    endproperty
    a_block_wrap: assert property (p_block_wrap) else $error("block counter did not wrap");

    property p_recovered_pass;
        cs.subframe_strobe && cs.use_recovered |=> cs.status_valid && cs.status_bit == $past(cs.recovered_bit);
    endproperty
    a_recovered_pass: assert property (p_recovered_pass) else $error("recovered bit not passed");

    property p_unused_zero;
        cs.subframe_strobe && !cs.use_recovered && frame_reg >= `SPDCS_CS_USED_BITS |=> !cs.status_bit;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("bit beyond 39 not zero");

    property p_sampling_frequency_code_bit0;
        cs.subframe_strobe && !cs.use_recovered && frame_reg == 8'h18
            |=> cs.status_bit == $past(cs.fields.sampling_frequency_code[0]);
    endproperty
    a_sampling_frequency_code_bit0: assert property (p_sampling_frequency_code_bit0) else $error("frequency bit 24 wrong");

    property p_chan_left;
        cs.subframe_strobe && !cs.use_recovered && frame_reg == 8'h14 && cs.second_subframe
            && cs.fields.subframe2_channel_no == 2'h1 |=> cs.status_bit;
    endproperty
    a_chan_left: assert property (p_chan_left) else $error("subframe 2 channel bit 20 wrong");

    property p_chan_right;
        cs.subframe_strobe && !cs.use_recovered && frame_reg == 8'h15 && !cs.second_subframe
            |=> cs.status_bit == ($past(cs.fields.subframe1_channel_no) == 2'h2);
    endproperty
    a_chan_right: assert property (p_chan_right) else $error("subframe 1 channel bit 21 wrong");

endmodule // spdcs_cs_gen

/* File: testbench/spdcs_far_model.sv */
// far-side source model: serial input streams, subframe timing and recovered status
module spdcs_far_model (
    input  wire logic       clk,
    input  wire logic       enable,
    output logic            primary_stream,
    output logic [2:0]      pin_streams,
    output logic            strobe,
    output logic            second,
    output logic            recovered_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic s;
    initial begin
        {primary_stream, pin_streams, strobe, recovered_bit} = 6'h00;
        second = 1'b1;
    end
    // a frame is never left half sent: subframe 2 still follows after disable
    always @(negedge clk) begin
        s = enable ? ($urandom_range(2) != 0) : !second;
        strobe <= s;
        if (s) begin
            second <= ~second;
        end
        {primary_stream, pin_streams, recovered_bit} <= 5'($urandom);
    end
endmodule // spdcs_far_model

/* File: testbench/spdcs_top_tb_top.sv */
// self-checking bench of the channel status and input select bank
`include "spdcs_map.svh"
module spdcs_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic SYS_CLK, RESET, REG_WR_EN, PRIM, STB, SEC, REC, STATUS_OVERWRITE, en, mon_on, exp_b;
    logic [6:0] REG_ADDR;
    logic [7:0] REG_WR_DATA, REG_RD_DATA;
    logic [2:0] PINS, IS_IN, COMP;
    logic [1:0] TRANSMIT_SOURCE_SELECT;
    logic [15:0] TX_STATUS_LOW;
    logic PRIM_COMP, PWR_DN, RX_DECODER_IN, STATUS_BIT_OUT, STATUS_BIT_VALID;
    logic [7:0] sh [0:127];
    logic [6:0] ofs [0:8];
    int n_fail, check_count, n_strobe, idx, cyc;
    spdcs_top spdcs_top_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_WR_EN(REG_WR_EN), .REG_ADDR(REG_ADDR),
        .REG_WR_DATA(REG_WR_DATA), .REG_RD_DATA(REG_RD_DATA), .PRIMARY_SERIAL_INPUT(PRIM), .MULTI_PIN_IN(PINS),
        .MULTI_PIN_IS_INPUT(IS_IN), .MULTI_PIN_COMPARATOR(COMP), .PRIMARY_INPUT_COMPARATOR(PRIM_COMP),
        .RECEIVER_POWER_DOWN(PWR_DN), .RX_DECODER_IN(RX_DECODER_IN), .SUBFRAME_STROBE(STB), .SECOND_SUBFRAME(SEC),
        .TRANSMIT_SOURCE_SELECT(TRANSMIT_SOURCE_SELECT), .STATUS_OVERWRITE(STATUS_OVERWRITE),
        .RECOVERED_STATUS_BIT(REC), .TX_STATUS_LOW(TX_STATUS_LOW), .STATUS_BIT_OUT(STATUS_BIT_OUT),
        .STATUS_BIT_VALID(STATUS_BIT_VALID));
    spdcs_far_model spdcs_far_model_i (.clk(SYS_CLK), .enable(en), .primary_stream(PRIM), .pin_streams(PINS),
        .strobe(STB), .second(SEC), .recovered_bit(REC));
    // ----------------------------------------
    // expectations
    // ----------------------------------------
    function automatic logic [7:0] mask(input logic [6:0] a);
        case (a)
            `SPDCS_OFS_SRC_CHAN, `SPDCS_OFS_WORD_LEN, `SPDCS_OFS_PIN_CFG_B: return 8'hff;
            `SPDCS_OFS_SAMPLING_FREQUENCY_CODE_ACC: return 8'h3f;
            `SPDCS_OFS_MODE_SEL: return 8'h07;
            `SPDCS_OFS_PIN_CFG_C: return 8'h0f;
            `SPDCS_OFS_PWR_DN2: return 8'h20;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic exp_cs(input int k, input logic sec);
        logic [39:0] cs;
        logic [1:0]  ch;
        logic [7:0]  w;
        logic [7:0]  f;
        ch = sec ? sh[`SPDCS_OFS_SRC_CHAN][7:6] : sh[`SPDCS_OFS_SRC_CHAN][5:4];
        w = sh[`SPDCS_OFS_WORD_LEN];
        f = sh[`SPDCS_OFS_SAMPLING_FREQUENCY_CODE_ACC];
        cs = {w[7:4], w[3:1], w[0], 2'b00, f[5:4], f[3:0], 2'b00, ch == 2'b10, ch == 2'b01,
              sh[`SPDCS_OFS_SRC_CHAN][3:0], TX_STATUS_LOW};
        return (k < 40) ? cs[k] : 1'b0;
    endfunction
    function automatic logic [3:0] pin_cfg(input int i);
        return (i == 2) ? sh[`SPDCS_OFS_PIN_CFG_C][3:0] : sh[`SPDCS_OFS_PIN_CFG_B][4*i +: 4];
    endfunction
    function automatic logic exp_mux();
        logic [1:0] s;
        s = sh[`SPDCS_OFS_MODE_SEL][2:1];
        if (sh[`SPDCS_OFS_PWR_DN2][5]) return 1'b0;
        if (s == 2'b00) return PRIM;
        return (pin_cfg(s - 1) >= 4'he) ? PINS[s - 1] : 1'b0;
    endfunction
    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge SYS_CLK);
        REG_ADDR = a;
        REG_WR_DATA = d;
        REG_WR_EN = 1'b1;
        @(negedge SYS_CLK);
        REG_WR_EN = 1'b0;
        sh[a] = d & mask(a);
    endtask
    task automatic rd(input logic [6:0] a);
        @(negedge SYS_CLK);
        REG_ADDR = a;
        @(negedge SYS_CLK);
        check("register", sh[a], REG_RD_DATA);
    endtask
    function automatic logic [3:0] pick();
        return ($urandom_range(3) == 0) ? 4'($urandom) : {3'b111, 1'($urandom)};
    endfunction
    task automatic run_block(input logic [1:0] src, input logic ovw, input int n);
        for (int a = 0; a < 3; a++) wr(ofs[a], (a == 0 && src == 2'b10) ? {2'b01, 2'b10, 4'($urandom)} : 8'($urandom));
        TRANSMIT_SOURCE_SELECT = src;
        STATUS_OVERWRITE = ovw;
        TX_STATUS_LOW = 16'($urandom);
        n_strobe = 0;
        en <= 1'b1;
        for (int i = 0; i < LIMIT && n_strobe < n; i++) @(negedge SYS_CLK);
        en <= 1'b0;
        repeat (8) @(negedge SYS_CLK);
    endtask
    // ----------------------------------------
    // monitor, clock, timeout
    // ----------------------------------------
    always @(negedge SYS_CLK) begin
        if (mon_on) begin
            check("status_valid", 8'(STB), 8'(STATUS_BIT_VALID));
            if (STB) begin
                exp_b = (TRANSMIT_SOURCE_SELECT == 2'b00 && !STATUS_OVERWRITE) ? REC : exp_cs(idx, SEC);
                check("status_bit", 8'(exp_b), 8'(STATUS_BIT_OUT));
                n_strobe++;
                if (SEC) idx = (idx + 1) % `SPDCS_BLOCK_FRAMES;
            end
        end
    end
    initial begin
        SYS_CLK = 1'b0;
        forever #2 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hb89422cd));
        {RESET, REG_WR_EN, REG_ADDR, REG_WR_DATA, STATUS_OVERWRITE, en, mon_on} = {1'b1, 19'h0};
        {TRANSMIT_SOURCE_SELECT, TX_STATUS_LOW, n_fail, check_count, idx, cyc} = '0;
        ofs = '{`SPDCS_OFS_SRC_CHAN, `SPDCS_OFS_SAMPLING_FREQUENCY_CODE_ACC, `SPDCS_OFS_WORD_LEN, `SPDCS_OFS_MODE_SEL,
                `SPDCS_OFS_PIN_CFG_B, `SPDCS_OFS_PIN_CFG_C, `SPDCS_OFS_PWR_DN2, 7'h25, 7'h7f};
        foreach (sh[i]) sh[i] = 8'h00;
        sh[ofs[0]] = `SPDCS_RST_SRC_CHAN;
        sh[ofs[1]] = `SPDCS_RST_SAMPLING_FREQUENCY_CODE_ACC;
        sh[ofs[2]] = `SPDCS_RST_WORD_LEN;
        sh[ofs[3]] = `SPDCS_RST_MODE_SEL;
        sh[ofs[4]] = `SPDCS_RST_PIN_CFG_B;
        sh[ofs[5]] = `SPDCS_RST_PIN_CFG_C;
        sh[ofs[6]] = `SPDCS_RST_PWR_DN2;
        repeat (5) @(negedge SYS_CLK);
        RESET = 1'b0;
        mon_on = 1'b1;
        for (int a = 0; a < 9; a++) rd(ofs[a]);
        TRANSMIT_SOURCE_SELECT = 2'b01;
        en <= 1'b1;
        for (int i = 0; i < LIMIT && n_strobe < 100; i++) @(negedge SYS_CLK);
        en <= 1'b0;
        repeat (8) @(negedge SYS_CLK);
        for (int p = 0; p < 3; p++) begin
            for (int a = 0; a < 9; a++) wr(ofs[a], 8'($urandom));
            for (int a = 0; a < 9; a++) rd(ofs[a]);
        end
        for (int t = 0; t < 12; t++) begin
            wr(`SPDCS_OFS_PIN_CFG_B, {pick(), pick()});
            // first two passes: input 4 as comparator, then input 1 in cmos mode, receiver on
            wr(`SPDCS_OFS_PIN_CFG_C, (t == 0) ? 8'h0f : {4'h0, pick()});
            wr(`SPDCS_OFS_MODE_SEL, (t == 0) ? 8'h06 : (t == 1) ? 8'h00 : 8'($urandom));
            wr(`SPDCS_OFS_PWR_DN2, ($urandom_range(3) == 0 && t > 1) ? 8'h20 : 8'h00);
            repeat (2) @(negedge SYS_CLK);
            for (int c = 0; c < 8; c++) begin
                @(negedge SYS_CLK);
                check("decoder_in", 8'(exp_mux()), 8'(RX_DECODER_IN));
            end
            for (int i = 0; i < 3; i++) begin
                check("pin_input", 8'(pin_cfg(i) >= 4'he), 8'(IS_IN[i]));
                check("pin_comparator", 8'(pin_cfg(i) == 4'hf), 8'(COMP[i]));
            end
            check("primary_comparator", 8'(sh[`SPDCS_OFS_MODE_SEL][0]), 8'(PRIM_COMP));
            check("power_down", 8'(sh[`SPDCS_OFS_PWR_DN2][5]), 8'(PWR_DN));
        end
        run_block(2'b10, 1'b0, 2 * `SPDCS_BLOCK_FRAMES + 20);
        run_block(2'b00, 1'b0, 60);
        run_block(2'b00, 1'b1, 100);
        print_verdict();
    end
endmodule // spdcs_top_tb_top
